/* File: hw/phy_ext_map.svh */
`ifndef PHY_EXT_MAP_SVH
`define PHY_EXT_MAP_SVH

// ----------------------------------------------------------------
// Direct management indices
// ----------------------------------------------------------------
`define IDX_SPECIAL_CTRL_STAT 5'h1F
`define IDX_EXT_ACCESS_CONTROL 5'h0D
`define IDX_EXT_INDEX_OR_VALUE 5'h0E

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCS_AUTODONE_BIT 12
`define SCS_FIELD_HI 11
`define SCS_FIELD_LO 5
`define SCS_SPEED_HI 4
`define SCS_SPEED_LO 2
`define ACC_FUNC_HI 15
`define ACC_FUNC_LO 14
`define ACC_SPACE_HI 4
`define ACC_SPACE_LO 0

// ----------------------------------------------------------------
// Reset values and access function codes
// ----------------------------------------------------------------
`define SCS_FIELD_RESET 7'h02
`define FUNC_ADDRESS 2'h0
`define FUNC_DATA 2'h1

// ----------------------------------------------------------------
// Extended space addresses
// ----------------------------------------------------------------
`define SPACE_PCS 5'h03
`define SPACE_NEG 5'h07
`define SPACE_VENDOR 5'h1E

// ----------------------------------------------------------------
// Extended indices
// ----------------------------------------------------------------
`define X_PCS_CTL1 16'h0000
`define X_PCS_STAT1 16'h0001
`define X_PRESENT_LOW 16'h0005
`define X_PRESENT_HIGH 16'h0006
`define X_EFF_CAP 16'h0014
`define X_WAKE_ERR 16'h0016
`define X_WAKE_CTRL 16'h8010
`define X_WAKE_CFG_A 16'h8011
`define X_WAKE_CFG_B 16'h8012
`define X_MASK_BASE 16'h8021
`define X_RX_ADDR_BASE 16'h8061
`define X_EFF_ADV 16'h003C
`define X_EFF_LP_ADV 16'h003D
`define X_VEND_ID1 16'h0002
`define X_VEND_ID2 16'h0003
`define X_VEND_STATE 16'h0008
`define X_VEND_PKG1 16'h000E
`define X_VEND_PKG2 16'h000F
`define X_Q_MEAN_ERR 16'h0010
`define X_Q_MSE 16'h0011
`define X_Q_MSE_WC 16'h0012
`define X_Q_SQI 16'h0013
`define X_Q_PEAK 16'h0014
`define X_Q_CTL 16'h0015
`define X_Q_CFG 16'h0016
`define X_Q_TBL_BASE 16'h0017

// ----------------------------------------------------------------
// Constant read values
// ----------------------------------------------------------------
`define PRESENT_LOW_VAL 16'h0088
`define PRESENT_HIGH_VAL 16'h4000
`define EFF_CAP_VAL 16'h0002

`endif

/* File: hw/phy_ext_pkg.sv */
package phy_ext_pkg;

    // Management request carried with its valid strobe
    typedef struct packed {
        logic we;
        logic [4:0] idx;
        logic [15:0] wdata;
    } mgmt_req_t;

    // Live measurements from the PHY core
    typedef struct packed {
        logic [15:0] vend_state;
        logic [15:0] mean_err;
        logic [15:0] mse;
        logic [15:0] mse_worst;
        logic [15:0] sqi;
        logic [15:0] peak_mse;
        logic [15:0] lp_adv;
    } phy_measure_t;

    // Software settings handed to the PHY core
    typedef struct packed {
        logic [6:0] special_field;
        logic [15:0] wake_ctrl;
        logic [15:0] eff_adv;
        logic [15:0] quality_ctl;
        logic [15:0] quality_cfg;
    } phy_settings_t;

    // Extended access function
    typedef enum logic [1:0] {
        FN_ADDRESS,
        FN_DATA,
        FN_OTHER_A,
        FN_OTHER_B
    } access_fn_t;

endpackage

/* File: hw/phy_special_status_mmd.sv */
`timescale 1ns/1ps
`include "phy_ext_map.svh"

module phy_special_status_mmd #(
    parameter int MASK_COUNT = 8,
    parameter int RX_ADDR_COUNT = 3,
    parameter int TABLE_COUNT = 7,
    parameter logic [15:0] VEND_ID1 = 16'h1234, // Arbitrary value
    parameter logic [15:0] VEND_ID2 = 16'h5678, // Arbitrary value
    parameter logic [15:0] VEND_PKG1 = 16'h1234, // Arbitrary value
    parameter logic [15:0] VEND_PKG2 = 16'h5678 // Arbitrary value
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mgmt_valid_i,
    input phy_ext_pkg::mgmt_req_t mgmt_req_i,
    output logic mgmt_ack_o,
    output logic [15:0] mgmt_rdata_o,
    input wire logic an_done_i,
    input wire logic [2:0] speed_duplex_i,
    input wire logic wake_err_evt_i,
    input phy_ext_pkg::phy_measure_t measure_i,
    output phy_ext_pkg::phy_settings_t settings_o
);
    import phy_ext_pkg::*;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    logic rd_scs;
    logic wr_scs;
    logic rd_acc;
    logic wr_acc;
    logic rd_val;
    logic wr_val;
    logic data_mode;
    logic ext_rd;
    logic ext_wr;

    // Direct index decode for the three registers of this block
    assign rd_scs = mgmt_valid_i && !mgmt_req_i.we && (mgmt_req_i.idx == `IDX_SPECIAL_CTRL_STAT);
    assign wr_scs = mgmt_valid_i && mgmt_req_i.we && (mgmt_req_i.idx == `IDX_SPECIAL_CTRL_STAT);
    assign rd_acc = mgmt_valid_i && !mgmt_req_i.we && (mgmt_req_i.idx == `IDX_EXT_ACCESS_CONTROL);
    assign wr_acc = mgmt_valid_i && mgmt_req_i.we && (mgmt_req_i.idx == `IDX_EXT_ACCESS_CONTROL);
    assign rd_val = mgmt_valid_i && !mgmt_req_i.we && (mgmt_req_i.idx == `IDX_EXT_INDEX_OR_VALUE);
    assign wr_val = mgmt_valid_i && mgmt_req_i.we && (mgmt_req_i.idx == `IDX_EXT_INDEX_OR_VALUE);

    // ------------------------------------------------------------
    // Special control/status register
    // ------------------------------------------------------------
    logic an_done_q;
    logic [2:0] speed_q;
    logic [6:0] scs_field_q;

    // Auto-negotiation done flag follows the PHY core
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            an_done_q <= 1'b0;
        end else begin
            an_done_q <= an_done_i;
        end
    end

    // Resolved speed and duplex code
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            speed_q <= 3'h0;
        end else begin
            speed_q <= speed_duplex_i;
        end
    end

    // Read/write field of the special register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scs_field_q <= `SCS_FIELD_RESET;
        end else if (wr_scs) begin
            scs_field_q <= mgmt_req_i.wdata[`SCS_FIELD_HI:`SCS_FIELD_LO];
        end
    end

    logic [15:0] scs_value;

    // Assemble the special register; reserved bits read zero
    always_comb begin
        scs_value = 16'h0000;
        scs_value[`SCS_AUTODONE_BIT] = an_done_q;
        scs_value[`SCS_FIELD_HI:`SCS_FIELD_LO] = scs_field_q;
        scs_value[`SCS_SPEED_HI:`SCS_SPEED_LO] = speed_q;
    end

    // ------------------------------------------------------------
    // Extended access control
    // ------------------------------------------------------------
    access_fn_t func_q;
    logic [4:0] space_sel_q;
    logic [4:0] space_lat_q;
    logic [15:0] index_q;

    // Function and space select fields
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            func_q <= FN_ADDRESS;
            space_sel_q <= 5'h00;
        end else if (wr_acc) begin
            func_q <= access_fn_t'(mgmt_req_i.wdata[`ACC_FUNC_HI:`ACC_FUNC_LO]);
            space_sel_q <= mgmt_req_i.wdata[`ACC_SPACE_HI:`ACC_SPACE_LO];
        end
    end

    // Any function other than address acts as data
    assign data_mode = (func_q != FN_ADDRESS);
    assign ext_rd = rd_val && data_mode;
    assign ext_wr = wr_val && data_mode;

    // Address step latches space and index; data steps leave them alone
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            index_q <= 16'h0000;
            space_lat_q <= 5'h00;
        end else if (wr_val && !data_mode) begin
            index_q <= mgmt_req_i.wdata;
            space_lat_q <= space_sel_q;
        end
    end

    logic [15:0] acc_value;

    // Access-control readback
    always_comb begin
        acc_value = 16'h0000;
        acc_value[`ACC_FUNC_HI:`ACC_FUNC_LO] = func_q;
        acc_value[`ACC_SPACE_HI:`ACC_SPACE_LO] = space_sel_q;
    end

    // ------------------------------------------------------------
    // Target select
    // ------------------------------------------------------------
    logic in_pcs;
    logic in_neg;
    logic in_vend;
    logic [15:0] mask_off;
    logic [15:0] rx_off;
    logic [15:0] tbl_off;

    // Only the three documented spaces are recognised
    assign in_pcs = (space_lat_q == `SPACE_PCS);
    assign in_neg = (space_lat_q == `SPACE_NEG);
    assign in_vend = (space_lat_q == `SPACE_VENDOR);
    assign mask_off = index_q - `X_MASK_BASE;
    assign rx_off = index_q - `X_RX_ADDR_BASE;
    assign tbl_off = index_q - `X_Q_TBL_BASE;

    // ------------------------------------------------------------
    // Writable extended registers
    // ------------------------------------------------------------
    logic [15:0] wake_ctrl_q;
    logic [15:0] wake_cfg_a_q;
    logic [15:0] wake_cfg_b_q;
    logic [15:0] eff_adv_q;
    logic [15:0] q_ctl_q;
    logic [15:0] q_cfg_q;
    logic [15:0] mask_q [MASK_COUNT];
    logic [15:0] rx_addr_q [RX_ADDR_COUNT];
    logic [15:0] tbl_q [TABLE_COUNT];

    // PCS wake registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_ctrl_q <= 16'h0000;
            wake_cfg_a_q <= 16'h0000;
            wake_cfg_b_q <= 16'h0000;
        end else if (ext_wr && in_pcs) begin
            case (index_q)
                `X_WAKE_CTRL: begin
                    wake_ctrl_q <= mgmt_req_i.wdata;
                end
                `X_WAKE_CFG_A: begin
                    wake_cfg_a_q <= mgmt_req_i.wdata;
                end
                `X_WAKE_CFG_B: begin
                    wake_cfg_b_q <= mgmt_req_i.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Negotiation advertisement
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eff_adv_q <= 16'h0000;
        end else if (ext_wr && in_neg && (index_q == `X_EFF_ADV)) begin
            eff_adv_q <= mgmt_req_i.wdata;
        end
    end

    // Vendor quality control and configuration
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_ctl_q <= 16'h0000;
            q_cfg_q <= 16'h0000;
        end else if (ext_wr && in_vend) begin
            case (index_q)
                `X_Q_CTL: begin
                    q_ctl_q <= mgmt_req_i.wdata;
                end
                `X_Q_CFG: begin
                    q_cfg_q <= mgmt_req_i.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Per-entry register arrays
    genvar gi;
    generate
        for (gi = 0; gi < MASK_COUNT; gi++) begin : g_mask
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    mask_q[gi] <= 16'h0000;
                end else if (ext_wr && in_pcs && (mask_off == 16'(gi))) begin
                    mask_q[gi] <= mgmt_req_i.wdata;
                end
            end
        end
        for (gi = 0; gi < RX_ADDR_COUNT; gi++) begin : g_rx
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    rx_addr_q[gi] <= 16'h0000;
                end else if (ext_wr && in_pcs && (rx_off == 16'(gi))) begin
                    rx_addr_q[gi] <= mgmt_req_i.wdata;
                end
            end
        end
        for (gi = 0; gi < TABLE_COUNT; gi++) begin : g_tbl
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    tbl_q[gi] <= 16'h0000;
                end else if (ext_wr && in_vend && (tbl_off == 16'(gi))) begin
                    tbl_q[gi] <= mgmt_req_i.wdata;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Wake error counter
    // ------------------------------------------------------------
    logic [15:0] wake_err_q;
    logic wake_err_clr;

    assign wake_err_clr = ext_rd && in_pcs && (index_q == `X_WAKE_ERR);

    // Clear on read, event in the same cycle still counts, hold at all ones
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_err_q <= 16'h0000;
        end else if (wake_err_clr) begin
            wake_err_q <= wake_err_evt_i ? 16'h0001 : 16'h0000;
        end else if (wake_err_evt_i && (wake_err_q != 16'hFFFF)) begin
            wake_err_q <= wake_err_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Extended read mux
    // ------------------------------------------------------------
    logic [15:0] ext_value;

    // Unknown space or index reads zero
    always_comb begin
        ext_value = 16'h0000;
        if (in_pcs) begin
            case (index_q)
                `X_PCS_CTL1: ext_value = 16'h0000;
                `X_PCS_STAT1: ext_value = 16'h0000;
                `X_PRESENT_LOW: ext_value = `PRESENT_LOW_VAL;
                `X_PRESENT_HIGH: ext_value = `PRESENT_HIGH_VAL;
                `X_EFF_CAP: ext_value = `EFF_CAP_VAL;
                `X_WAKE_ERR: ext_value = wake_err_q;
                `X_WAKE_CTRL: ext_value = wake_ctrl_q;
                `X_WAKE_CFG_A: ext_value = wake_cfg_a_q;
                `X_WAKE_CFG_B: ext_value = wake_cfg_b_q;
                default: begin
                    if (mask_off < 16'(MASK_COUNT)) begin
                        ext_value = mask_q[mask_off[2:0]];
                    end else if (rx_off < 16'(RX_ADDR_COUNT)) begin
                        ext_value = rx_addr_q[rx_off[1:0]];
                    end
                end
            endcase
        end else if (in_neg) begin
            case (index_q)
                `X_PRESENT_LOW: ext_value = `PRESENT_LOW_VAL;
                `X_PRESENT_HIGH: ext_value = `PRESENT_HIGH_VAL;
                `X_EFF_ADV: ext_value = eff_adv_q;
                `X_EFF_LP_ADV: ext_value = measure_i.lp_adv;
                default: ext_value = 16'h0000;
            endcase
        end else if (in_vend) begin
            case (index_q)
                `X_VEND_ID1: ext_value = VEND_ID1;
                `X_VEND_ID2: ext_value = VEND_ID2;
                `X_PRESENT_LOW: ext_value = `PRESENT_LOW_VAL;
                `X_PRESENT_HIGH: ext_value = `PRESENT_HIGH_VAL;
                `X_VEND_STATE: ext_value = measure_i.vend_state;
                `X_VEND_PKG1: ext_value = VEND_PKG1;
                `X_VEND_PKG2: ext_value = VEND_PKG2;
                `X_Q_MEAN_ERR: ext_value = measure_i.mean_err;
                `X_Q_MSE: ext_value = measure_i.mse;
                `X_Q_MSE_WC: ext_value = measure_i.mse_worst;
                `X_Q_SQI: ext_value = measure_i.sqi;
                `X_Q_PEAK: ext_value = measure_i.peak_mse;
                `X_Q_CTL: ext_value = q_ctl_q;
                `X_Q_CFG: ext_value = q_cfg_q;
                default: begin
                    if (tbl_off < 16'(TABLE_COUNT)) begin
                        ext_value = tbl_q[tbl_off[2:0]];
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Management answer
    // ------------------------------------------------------------
    logic [15:0] rd_value;

    // Extended space shows only through the index/value register
    always_comb begin
        rd_value = 16'h0000;
        if (rd_scs) begin
            rd_value = scs_value;
        end else if (rd_acc) begin
            rd_value = acc_value;
        end else if (rd_val) begin
            rd_value = data_mode ? ext_value : index_q;
        end
    end

    // Answer one cycle after every request
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mgmt_ack_o <= 1'b0;
            mgmt_rdata_o <= 16'h0000;
        end else begin
            mgmt_ack_o <= mgmt_valid_i;
            mgmt_rdata_o <= mgmt_valid_i ? rd_value : 16'h0000;
        end
    end

    // Settings to the PHY core come straight from flops
    assign settings_o.special_field = scs_field_q;
    assign settings_o.wake_ctrl = wake_ctrl_q;
    assign settings_o.eff_adv = eff_adv_q;
    assign settings_o.quality_ctl = q_ctl_q;
    assign settings_o.quality_cfg = q_cfg_q;

endmodule

/* File: test/phy_ext_checker.sv */
`timescale 1ns/1ps
module phy_ext_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mgmt_valid_i,
    input phy_ext_pkg::mgmt_req_t mgmt_req_i,
    input wire logic mgmt_ack_o,
    input wire logic [15:0] mgmt_rdata_o,
    input wire logic an_done_i,
    input wire logic [2:0] speed_duplex_i,
    input phy_ext_pkg::phy_settings_t settings_o
);
    import phy_ext_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // ----------------------------------------------------------------
    // Request shapes
    // ----------------------------------------------------------------
    sequence s_rd(i);
        mgmt_valid_i && !mgmt_req_i.we && mgmt_req_i.idx == i;
    endsequence
    sequence s_wr(i);
        mgmt_valid_i && mgmt_req_i.we && mgmt_req_i.idx == i;
    endsequence

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_ack_follows: assert property (mgmt_valid_i |=> mgmt_ack_o)
        else $error("no answer one cycle after a request");
    a_idle_quiet: assert property (!mgmt_valid_i |=> !mgmt_ack_o && mgmt_rdata_o == 16'h0000)
        else $error("answer or data without a request");
    a_write_no_data: assert property (mgmt_valid_i && mgmt_req_i.we |=> mgmt_rdata_o == 16'h0000)
        else $error("write returned data");
    a_unmapped_zero: assert property (mgmt_valid_i && !mgmt_req_i.we
        && !(mgmt_req_i.idx inside {5'h1F, 5'h0D, 5'h0E}) |=> mgmt_rdata_o == 16'h0000)
        else $error("unmapped index read not zero");
    a_status_bits: assert property ((s_rd(5'h1F) ##0 ($past(rst_n_i) && $stable(an_done_i)
        && $stable(speed_duplex_i))) |=> mgmt_rdata_o[15:13] == 3'b000 && mgmt_rdata_o[1:0] == 2'b00
        && mgmt_rdata_o[12] == $past(an_done_i) && mgmt_rdata_o[4:2] == $past(speed_duplex_i))
        else $error("status bits differ from core state");
    a_field_write: assert property (s_wr(5'h1F) |=> {4'h0, settings_o.special_field, 5'h00}
        == ($past(mgmt_req_i.wdata) & 16'h0FE0))
        else $error("writable field not taken");
    a_ctrl_readback: assert property (s_wr(5'h0D) ##1 s_rd(5'h0D)
        |=> mgmt_rdata_o == ($past(mgmt_req_i.wdata, 2) & 16'hC01F))
        else $error("access control reads back wrong");
    a_settings_cause: assert property (!$stable(settings_o) |-> $past(mgmt_valid_i) && $past(mgmt_req_i.we))
        else $error("settings changed without a write");
endmodule

bind phy_special_status_mmd phy_ext_checker i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mgmt_valid_i(mgmt_valid_i), .mgmt_req_i(mgmt_req_i), .mgmt_ack_o(mgmt_ack_o),
    .mgmt_rdata_o(mgmt_rdata_o), .an_done_i(an_done_i), .speed_duplex_i(speed_duplex_i),
    .settings_o(settings_o));

/* File: test/tb.sv */
`timescale 1ns/1ps
`include "phy_ext_map.svh"
module tb;
    import phy_ext_pkg::*;
    localparam logic [15:0] ID1 = 16'hA51C; // Arbitrary value
    localparam logic [15:0] ID2 = 16'h3C7E; // Arbitrary value
    localparam logic [15:0] PKG1 = 16'h0F42; // Arbitrary value
    localparam logic [15:0] PKG2 = 16'h6D19; // Arbitrary value
    logic clk_i, rst_n_i, mgmt_valid_i, mgmt_ack_o, an_done_i, wake_err_evt_i;
    logic [15:0] mgmt_rdata_o, rdv;
    logic [2:0] speed_duplex_i;
    mgmt_req_t mgmt_req_i;
    phy_measure_t measure_i;
    phy_settings_t settings_o;
    int n_mismatch, n_compared;

    phy_special_status_mmd #(.VEND_ID1(ID1), .VEND_ID2(ID2), .VEND_PKG1(PKG1), .VEND_PKG2(PKG2)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .mgmt_valid_i(mgmt_valid_i), .mgmt_req_i(mgmt_req_i),
        .mgmt_ack_o(mgmt_ack_o), .mgmt_rdata_o(mgmt_rdata_o), .an_done_i(an_done_i),
        .speed_duplex_i(speed_duplex_i), .wake_err_evt_i(wake_err_evt_i), .measure_i(measure_i),
        .settings_o(settings_o));

    // ----------------------------------------------------------------
    // Clock, helpers
    // ----------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One request; valid stays up so callers can go back to back
    task automatic acc(input logic we, input logic [4:0] idx, input logic [15:0] wd);
        mgmt_valid_i = 1'b1;
        mgmt_req_i = '{we: we, idx: idx, wdata: wd};
        @(posedge clk_i);
        #1;
        chk({15'h0000, mgmt_ack_o}, 16'h0001, "ack");
        rdv = mgmt_rdata_o;
    endtask

    task automatic idle(input int n);
        mgmt_valid_i = 1'b0;
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic rdc(input logic [4:0] idx, input logic [15:0] exp, input string what);
        acc(1'b0, idx, 16'h0000);
        chk(rdv, exp, what);
    endtask

    // Address step, then select the data function on the same space
    task automatic sel(input logic [4:0] sp, input logic [15:0] ix);
        acc(1'b1, `IDX_EXT_ACCESS_CONTROL, {2'b00, 9'h000, sp});
        rdc(`IDX_EXT_ACCESS_CONTROL, {11'h000, sp}, "ctrl");
        acc(1'b1, `IDX_EXT_INDEX_OR_VALUE, ix);
        rdc(`IDX_EXT_INDEX_OR_VALUE, ix, "latched index");
        acc(1'b1, `IDX_EXT_ACCESS_CONTROL, {2'b01, 9'h000, sp});
    endtask

    task automatic xw(input logic [4:0] sp, input logic [15:0] ix, input logic [15:0] v);
        sel(sp, ix);
        acc(1'b1, `IDX_EXT_INDEX_OR_VALUE, v);
    endtask

    task automatic xr(input logic [4:0] sp, input logic [15:0] ix, input logic [15:0] exp);
        sel(sp, ix);
        rdc(`IDX_EXT_INDEX_OR_VALUE, exp, "ext read");
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_special;
        logic [2:0] codes[4] = '{3'b001, 3'b010, 3'b101, 3'b110};
        rdc(`IDX_SPECIAL_CTRL_STAT, 16'h0040, "reset value");
        chk({9'h000, settings_o.special_field}, 16'h0002, "field reset");
        foreach (codes[k]) begin
            an_done_i = k[0];
            speed_duplex_i = codes[k];
            idle(2);
            rdc(`IDX_SPECIAL_CTRL_STAT, {3'b000, k[0], 7'h02, codes[k], 2'b00}, "status");
        end
        acc(1'b1, `IDX_SPECIAL_CTRL_STAT, 16'h0AA0);
        rdc(`IDX_SPECIAL_CTRL_STAT, {3'b000, an_done_i, 7'h55, speed_duplex_i, 2'b00}, "field");
        chk({9'h000, settings_o.special_field}, 16'h0055, "field out");
        rdc(5'h00, 16'h0000, "unmapped");
        rdc(5'h1E, 16'h0000, "unmapped");
        $display("test special done");
    endtask

    task automatic t_consts;
        xr(`SPACE_PCS, 16'd5, 16'h0088);
        xr(`SPACE_PCS, 16'd6, 16'h4000);
        xr(`SPACE_PCS, 16'd20, 16'h0002);
        xr(`SPACE_PCS, 16'd0, 16'h0000);
        xr(`SPACE_PCS, 16'd1, 16'h0000);
        xw(`SPACE_PCS, 16'd5, 16'h0000);
        xr(`SPACE_PCS, 16'd5, 16'h0088);
        xr(`SPACE_NEG, 16'd5, 16'h0088);
        xr(`SPACE_NEG, 16'd6, 16'h4000);
        xr(`SPACE_NEG, 16'd61, measure_i.lp_adv);
        xr(`SPACE_VENDOR, 16'd5, 16'h0088);
        xr(`SPACE_VENDOR, 16'd6, 16'h4000);
        xr(`SPACE_VENDOR, 16'd2, ID1);
        xr(`SPACE_VENDOR, 16'd3, ID2);
        xr(`SPACE_VENDOR, 16'd8, measure_i.vend_state);
        xr(`SPACE_VENDOR, 16'd14, PKG1);
        xr(`SPACE_VENDOR, 16'd15, PKG2);
        xr(`SPACE_VENDOR, 16'd16, measure_i.mean_err);
        xr(`SPACE_VENDOR, 16'd17, measure_i.mse);
        xr(`SPACE_VENDOR, 16'd18, measure_i.mse_worst);
        xr(`SPACE_VENDOR, 16'd19, measure_i.sqi);
        xr(`SPACE_VENDOR, 16'd20, measure_i.peak_mse);
        $display("test constants done");
    endtask

    // Every writable extended register gets its own value, then all are read back
    task automatic t_rw;
        logic [4:0] gsp[6] = '{5'd3, 5'd3, 5'd3, 5'd7, 5'd30, 5'd30};
        logic [15:0] gix[6] = '{16'h8010, 16'h8021, 16'h8061, 16'h003C, 16'h0015, 16'h0017};
        int gn[6] = '{3, 8, 3, 1, 2, 7};
        logic [4:0] sp[$];
        logic [15:0] ix[$];
        for (int g = 0; g < 6; g++) begin
            for (int j = 0; j < gn[g]; j++) begin
                sp.push_back(gsp[g]);
                ix.push_back(gix[g] + 16'(j));
            end
        end
        foreach (sp[k]) xw(sp[k], ix[k], 16'h5A00 + 16'(k));
        foreach (sp[k]) xr(sp[k], ix[k], 16'h5A00 + 16'(k));
        chk(settings_o.wake_ctrl, 16'h5A00, "wake out");
        chk(settings_o.eff_adv, 16'h5A0E, "adv out");
        chk(settings_o.quality_ctl, 16'h5A0F, "ctl out");
        chk(settings_o.quality_cfg, 16'h5A10, "cfg out");
        $display("test read write done");
    endtask

    task automatic t_edges;
        xr(`SPACE_PCS, 16'h8020, 16'h0000);
        xr(`SPACE_PCS, 16'h8029, 16'h0000);
        xr(`SPACE_PCS, 16'h8064, 16'h0000);
        xr(`SPACE_NEG, 16'd62, 16'h0000);
        xr(`SPACE_VENDOR, 16'd30, 16'h0000);
        xw(5'd5, 16'd0, 16'hFFFF);
        xr(5'd5, 16'd0, 16'h0000);
        xw(`SPACE_NEG, 16'h8010, 16'hFFFF);
        xr(`SPACE_PCS, 16'h8010, 16'h5A00);
        rdc(`IDX_EXT_INDEX_OR_VALUE, 16'h5A00, "repeat");
        acc(1'b1, `IDX_EXT_ACCESS_CONTROL, {2'b01, 9'h000, `SPACE_NEG});
        rdc(`IDX_EXT_INDEX_OR_VALUE, 16'h5A00, "latched");
        acc(1'b1, `IDX_EXT_INDEX_OR_VALUE, 16'h1357);
        rdc(`IDX_EXT_INDEX_OR_VALUE, 16'h1357, "data write");
        // Function 10 behaves as data and keeps the latched target
        acc(1'b1, `IDX_EXT_ACCESS_CONTROL, {2'b10, 9'h000, `SPACE_PCS});
        rdc(`IDX_EXT_INDEX_OR_VALUE, 16'h1357, "other function");
        $display("test edges done");
    endtask

    task automatic t_counter;
        sel(`SPACE_PCS, 16'd22);
        rdc(`IDX_EXT_INDEX_OR_VALUE, 16'h0000, "count idle");
        idle(1);
        repeat (3) begin
            wake_err_evt_i = 1'b1;
            @(posedge clk_i);
            #1;
            wake_err_evt_i = 1'b0;
            @(posedge clk_i);
            #1;
        end
        rdc(`IDX_EXT_INDEX_OR_VALUE, 16'h0003, "count");
        rdc(`IDX_EXT_INDEX_OR_VALUE, 16'h0000, "cleared");
        idle(1);
        wake_err_evt_i = 1'b1;
        repeat (65540) @(posedge clk_i);
        #1;
        // Event still high in the clearing read: it counts as one
        rdc(`IDX_EXT_INDEX_OR_VALUE, 16'hFFFF, "saturated");
        wake_err_evt_i = 1'b0;
        rdc(`IDX_EXT_INDEX_OR_VALUE, 16'h0001, "event in clear");
        rdc(`IDX_EXT_INDEX_OR_VALUE, 16'h0000, "cleared");
        idle(1);
        $display("test counter done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0;
        mgmt_valid_i = 1'b0;
        mgmt_req_i = '0;
        an_done_i = 1'b0;
        speed_duplex_i = 3'b000;
        wake_err_evt_i = 1'b0;
        measure_i = {16'hB001, 16'hB002, 16'hB003, 16'hB004, 16'hB005, 16'hB006, 16'hB007};
        repeat (10) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        t_special();
        t_consts();
        t_rw();
        t_edges();
        t_counter();
        stop_test();
    end

    initial begin
        #2000000;
        n_mismatch++;
        stop_test();
    end
endmodule
